// ===== mtx_serializer.sv
`timescale 1ns/1ps
`include "mtx_params.svh"
// Overview of operation
// (R1) Synchronous mode sends all eight buffer bits, b0 first.
// (R2) Start-stop: start bit, 5-8 data bits from b0, optional parity, stop bits.
// (R3) Start, parity and stop bits are generated here, never from host data.
// (R4) Each holding-to-buffer transfer sets the buffer-ready flag.
// (R5) A host write to the data register clears the buffer-ready flag.
// (R6) Transfer due with no new byte sets the underflow flag.
// (R7) Underflow in synchronous mode resends the previous buffer.
// (R8) Underflow in start-stop mode sends continuous stop level until a new byte.
// (R9) Data register answers at 0xE3 and 0xE4; host normally uses 0xE3.
// (R10) QAM/DPSK start-stop: 0xE4 byte sends one stop bit fewer.
// (R11) FSK start-stop: 0xE4 byte ends with stop bit shortened by 12.5%.
// (R12) Synchronous modes treat 0xE4 exactly like 0xE3.
// (R13) Start-stop waits for data by inserting extra stop bits.
// (R14) Host deletes at most one stop in 8 or 4 characters.
// (R15) Scrambler inverts next input bit after 64 consecutive input ones.
// (R16) Self-synchronising scrambler, taps at delays 14 and 17.
// (R17) Bits pass scrambler then to FSK or phase modulator by mode.
// (R18) Phase modulator: 600 baud, 1200Hz calling or 2400Hz answering carrier.
// (R19) 600bps DPSK: bit 0 gives +90 degrees, bit 1 gives +270.
// (R20) 1200bps dibits: 00 +90, 01 0, 11 +270, 10 +180.
// (R21) 2400bps QAM: quads; first dibit quadrant change, last dibit point.
// (R22) Standby disables transmit path; control port stays alive.
// (R23) Transaction: one address byte, then one or more data bytes.
// (R24) Scrambler disabled passes bits unchanged to the modulator.
module mtx_serializer
  import mtx_pkg::*;
#(
  parameter int unsigned DIV_75   = `MTX_CLK_HZ / `MTX_RATE_75,
  parameter int unsigned DIV_150  = `MTX_CLK_HZ / `MTX_RATE_150,
  parameter int unsigned DIV_300  = `MTX_CLK_HZ / `MTX_RATE_300,
  parameter int unsigned DIV_600  = `MTX_CLK_HZ / `MTX_RATE_600,
  parameter int unsigned DIV_1200 = `MTX_CLK_HZ / `MTX_RATE_1200,
  parameter int unsigned DIV_2400 = `MTX_CLK_HZ / `MTX_RATE_2400
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       link_clk,
  input  wire logic       cs_b,
  input  wire logic       cmd_data,
  input  wire mtx_modem_e tx_modem,
  input  wire logic       start_stop,
  input  wire logic [1:0] data_bits,
  input  wire logic       parity_en,
  input  wire logic       parity_even,
  input  wire logic       two_stop,
  input  wire logic       scram_en,
  input  wire logic       answer_mode,
  input  wire logic       powersave,
  output logic            tx_ready,
  output logic            tx_underflow,
  output logic            line_bit,
  output logic            bit_strobe,
  output logic            fsk_active,
  output logic            carrier_high,
  output logic [1:0]      phase_change,
  output logic [1:0]      quad_point,
  output logic            sym_strobe
);

  // --------------------------------------------------------------------------
  // Control port, link clock domain
  // --------------------------------------------------------------------------
  logic [2:0] lk_cnt;
  logic       lk_addr_done;
  logic [6:0] lk_shift;
  logic [7:0] lk_addr;
  logic [7:0] lk_byte;
  logic       lk_tog;
  logic [7:0] lk_wdata;
  logic       lk_wshort;

  assign lk_byte = {lk_shift, cmd_data};

  // Select going high ends the frame even though the link clock has stopped
  always_ff @(posedge link_clk or posedge cs_b)
  begin
    if (cs_b)
    begin
      lk_cnt       <= 3'h0;
      lk_addr_done <= 1'b0;
    end
    else
    begin
      lk_cnt <= lk_cnt + 3'h1;
      if (lk_cnt == 3'h7)
        lk_addr_done <= 1'b1;  // [R23]
    end
  end

  always_ff @(posedge link_clk)
  begin
    lk_shift <= lk_byte[6:0];
    if (lk_cnt == 3'h7 && !lk_addr_done)
      lk_addr <= lk_byte;  // [R23]
  end

  // Data word stays still between toggles, so the core reads it after sync
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lk_tog    <= 1'b0;
      lk_wdata  <= 8'h00;
      lk_wshort <= 1'b0;
    end
    else if (lk_cnt == 3'h7 && lk_addr_done &&
             (lk_addr == `MTX_ADDR_TX_NORMAL || lk_addr == `MTX_ADDR_TX_SHORT))
    begin
      lk_tog    <= ~lk_tog;  // [R9]
      lk_wdata  <= lk_byte;
      lk_wshort <= (lk_addr == `MTX_ADDR_TX_SHORT);  // [R9]
    end
  end

  // --------------------------------------------------------------------------
  // Crossing into the core clock and holding register
  // --------------------------------------------------------------------------
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;
  logic       wr_evt;
  logic [7:0] hold_data;
  logic       hold_short;
  logic       hold_full;
  logic       load;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      {tog_s1, tog_s2, tog_s3} <= 3'h0;
    else
      {tog_s1, tog_s2, tog_s3} <= {lk_tog, tog_s1, tog_s2};
  end

  assign wr_evt = tog_s2 ^ tog_s3;

  // A write landing with a transfer keeps the register full
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hold_data  <= 8'h00;
      hold_short <= 1'b0;
      hold_full  <= 1'b0;
    end
    else if (wr_evt)
    begin
      hold_data  <= lk_wdata;
      hold_short <= lk_wshort;
      hold_full  <= 1'b1;
    end
    else if (load)
      hold_full <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Bit timing
  // --------------------------------------------------------------------------
  function automatic logic [23:0] rate_div(input mtx_modem_e m);
    unique case (m)
      MTX_FSK_75:    return 24'(DIV_75);
      MTX_FSK_150:   return 24'(DIV_150);
      MTX_FSK_300:   return 24'(DIV_300);
      MTX_DPSK_600:  return 24'(DIV_600);
      MTX_FSK_1200,
      MTX_DPSK_1200: return 24'(DIV_1200);
      MTX_QAM_2400,
      MTX_OFF:       return 24'(DIV_2400);
    endcase
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] nb);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 8; i++)
      if (i < 5 + int'(nb))
        p = p ^ d[i];
    return p;
  endfunction

  logic        run;
  logic        is_fsk;
  logic [23:0] base_len;
  logic [23:0] short_len;
  logic [23:0] div_cnt;
  logic        tick;

  assign run       = !powersave && tx_modem != MTX_OFF;  // [R22]
  assign is_fsk    = tx_modem inside {MTX_FSK_300, MTX_FSK_1200, MTX_FSK_75, MTX_FSK_150};
  assign base_len  = rate_div(tx_modem);
  assign short_len = base_len - 24'(base_len / 24'(`MTX_SHORT_DIV));  // [R11]
  assign tick      = run && div_cnt == 24'h00_0000;

  // --------------------------------------------------------------------------
  // Character sequencer
  // --------------------------------------------------------------------------
  mtx_state_e  state;
  mtx_state_e  next_state;
  logic [7:0]  tx_buf;
  logic        buf_short;
  logic [2:0]  bit_idx;
  logic [2:0]  next_idx;
  logic [1:0]  stop_left;
  logic [1:0]  next_stop_left;
  logic [1:0]  stop_total;
  logic [2:0]  last_idx;
  logic        next_bit;
  logic [23:0] next_len;
  logic        go_stop;
  logic        go_fetch;
  logic        starve;

  assign last_idx   = 3'h4 + {1'b0, data_bits};
  assign stop_total = (two_stop ? 2'h2 : 2'h1) -
                      ((buf_short && !is_fsk) ? 2'h1 : 2'h0);  // [R10]

  always_comb
  begin
    next_state     = state;
    next_idx       = bit_idx;
    next_stop_left = stop_left;
    next_bit       = 1'b1;
    next_len       = base_len;
    go_stop        = 1'b0;
    go_fetch       = 1'b0;
    load           = 1'b0;
    starve         = 1'b0;
    unique case (state)
      MTX_S_IDLE:   go_fetch = 1'b1;
      MTX_S_START:
      begin
        next_bit   = tx_buf[0];  // [R2]
        next_idx   = 3'h0;
        next_state = MTX_S_DATA;
      end
      MTX_S_DATA:
      begin
        if (!start_stop ? bit_idx == 3'h7 : bit_idx == last_idx)
        begin
          if (!start_stop)
            go_fetch = 1'b1;  // [R1]
          else if (parity_en)
          begin
            next_bit   = par_of(tx_buf, data_bits) ^ ~parity_even;  // [R3]
            next_state = MTX_S_PARITY;
          end
          else
            go_stop = 1'b1;
        end
        else
        begin
          next_bit = tx_buf[bit_idx + 3'h1];  // [R1] [R2]
          next_idx = bit_idx + 3'h1;
        end
      end
      MTX_S_PARITY: go_stop = 1'b1;
      MTX_S_STOP:
      begin
        if (stop_left == 2'h0)
          go_fetch = 1'b1;
        else
        begin
          next_stop_left = stop_left - 2'h1;
          if (stop_left == 2'h1 && buf_short && is_fsk)
            next_len = short_len;  // [R11]
        end
      end
    endcase
    if (go_stop)
    begin
      if (stop_total == 2'h0)
        go_fetch = 1'b1;  // [R10]
      else
      begin
        next_state     = MTX_S_STOP;  // [R3]
        next_stop_left = stop_total - 2'h1;
        if (stop_total == 2'h1 && buf_short && is_fsk)
          next_len = short_len;  // [R11]
      end
    end
    if (go_fetch)
    begin
      load   = hold_full && tick;
      starve = !hold_full && tick;  // [R6]
      if (!start_stop)
      begin
        next_bit   = hold_full ? hold_data[0] : tx_buf[0];  // [R7]
        next_idx   = 3'h0;
        next_state = MTX_S_DATA;
      end
      else if (hold_full)
      begin
        next_bit   = 1'b0;  // [R3]
        next_state = MTX_S_START;
      end
      else
        next_state = MTX_S_IDLE;  // [R8] [R13]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || !run)
    begin
      state     <= MTX_S_IDLE;
      bit_idx   <= 3'h0;
      stop_left <= 2'h0;
      div_cnt   <= 24'h00_0000;
    end
    else if (tick)
    begin
      state     <= next_state;
      bit_idx   <= next_idx;
      stop_left <= next_stop_left;
      div_cnt   <= next_len - 24'h00_0001;
    end
    else
      div_cnt <= div_cnt - 24'h00_0001;
  end

  // Synchronous modes ignore the short flag, so it is only kept for start-stop
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_buf    <= 8'h00;
      buf_short <= 1'b0;
    end
    else if (load)
    begin
      tx_buf    <= hold_data;
      buf_short <= hold_short && start_stop;  // [R12]
    end
  end

  // --------------------------------------------------------------------------
  // Status flags; a transfer wins over a write in the same cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_ready     <= `MTX_READY_RST;
      tx_underflow <= 1'b0;
    end
    else
    begin
      if (load)
        tx_ready <= 1'b1;  // [R4]
      else if (wr_evt)
        tx_ready <= 1'b0;  // [R5]
      if (starve)
        tx_underflow <= 1'b1;  // [R6]
      else if (wr_evt)
        tx_underflow <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Scrambler
  // --------------------------------------------------------------------------
  logic [16:0] scr_sr;
  logic [6:0]  ones_cnt;
  logic        scr_inv;
  logic        scr_in;
  logic        scr_out;
  logic        raw_bit;

  assign scr_inv = ones_cnt == `MTX_ONES_LIMIT;  // [R15]
  assign scr_in  = next_bit ^ scr_inv;
  assign scr_out = scr_in ^ scr_sr[`MTX_SCR_TAP_A - 1] ^ scr_sr[`MTX_SCR_TAP_B - 1];  // [R16]

  always_ff @(posedge clk)
  begin
    if (!rst_b || !run)
    begin
      scr_sr     <= 17'h0_0000;
      ones_cnt   <= 7'h00;
      line_bit   <= 1'b1;  // [R22]
      raw_bit    <= 1'b1;
      bit_strobe <= 1'b0;
    end
    else
    begin
      bit_strobe <= tick;
      if (tick)
      begin
        raw_bit <= next_bit;
        if (scram_en)
        begin
          scr_sr   <= {scr_sr[15:0], scr_out};
          ones_cnt <= (next_bit && !scr_inv) ? ones_cnt + 7'h01 : 7'h00;
          line_bit <= scr_out;  // [R17]
        end
        else
        begin
          ones_cnt <= 7'h00;
          line_bit <= next_bit;  // [R24]
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Phase symbol mapper; phase codes count steps of 90 degrees
  // --------------------------------------------------------------------------
  function automatic logic [1:0] dibit_phase(input logic first, input logic second);
    unique case ({first, second})
      2'h0: return 2'h1;
      2'h1: return 2'h0;
      2'h3: return 2'h3;
      2'h2: return 2'h2;
    endcase
  endfunction

  logic [1:0] grp_cnt;
  logic [2:0] grp_bits;

  assign fsk_active   = run && is_fsk;  // [R17]
  assign carrier_high = answer_mode;  // [R18]

  always_ff @(posedge clk)
  begin
    if (!rst_b || !run || is_fsk)
    begin
      grp_cnt      <= 2'h0;
      grp_bits     <= 3'h0;
      phase_change <= 2'h0;
      quad_point   <= 2'h0;
      sym_strobe   <= 1'b0;
    end
    else
    begin
      sym_strobe <= 1'b0;
      if (bit_strobe)
      begin
        grp_bits <= {grp_bits[1:0], line_bit};
        grp_cnt  <= grp_cnt + 2'h1;
        unique case (tx_modem)
          MTX_DPSK_600:
          begin
            phase_change <= line_bit ? 2'h3 : 2'h1;  // [R19]
            sym_strobe   <= 1'b1;
            grp_cnt      <= 2'h0;
          end
          MTX_DPSK_1200:
            if (grp_cnt[0])
            begin
              phase_change <= dibit_phase(grp_bits[0], line_bit);  // [R20]
              sym_strobe   <= 1'b1;
              grp_cnt      <= 2'h0;
            end
          default:
            if (grp_cnt == 2'h3)
            begin
              phase_change <= dibit_phase(grp_bits[2], grp_bits[1]);  // [R21]
              quad_point   <= {grp_bits[0], line_bit};  // [R21]
              sym_strobe   <= 1'b1;
            end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_launch_char;
    load && start_stop;
  endsequence

  sequence s_starve_async;
    starve && start_stop && run;
  endsequence

  a_ready_on_load: assert property (load |=> tx_ready)  // [R4]
    else $error("ready not set on transfer");
  a_ready_on_write: assert property (wr_evt && !load |=> !tx_ready)  // [R5]
    else $error("ready not cleared by write");
  a_underflow_set: assert property (starve |=> tx_underflow)  // [R6]
    else $error("underflow not flagged");
  a_sync_resend: assert property (starve && !start_stop |=> tx_buf == $past(tx_buf))  // [R7]
    else $error("sync underflow changed buffer");
  a_stop_fill: assert property (s_starve_async |=> raw_bit && state == MTX_S_IDLE)  // [R8]
    else $error("idle not stop level");
  a_start_low: assert property (s_launch_char |=> !raw_bit && bit_strobe)  // [R3]
    else $error("start bit not low");
  a_sync_lsb: assert property (load && !start_stop |=> raw_bit == $past(hold_data[0]))  // [R1]
    else $error("sync word not lsb first");
  a_short_stop: assert property (tick && next_len == short_len && short_len != base_len
                                 |=> div_cnt == $past(short_len) - 24'h00_0001)  // [R11]
    else $error("short stop length wrong");
  a_scram_off: assert property (!scram_en && run ##1 bit_strobe |-> line_bit == raw_bit)  // [R24]
    else $error("unscrambled path altered bit");
  a_standby_quiet: assert property (powersave |=> line_bit && !sym_strobe && !bit_strobe)  // [R22]
    else $error("standby not quiet");

endmodule

// ===== mtx_params.svh
`ifndef MTX_PARAMS_SVH
`define MTX_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register addresses on the serial control port
// ----------------------------------------------------------------------------
`define MTX_ADDR_TX_NORMAL 8'he3
`define MTX_ADDR_TX_SHORT  8'he4

// ----------------------------------------------------------------------------
// Clock and line rates in Hz and bit/s
// ----------------------------------------------------------------------------
`define MTX_CLK_HZ    32'h0beb_c200
`define MTX_RATE_75   32'h0000_004b
`define MTX_RATE_150  32'h0000_0096
`define MTX_RATE_300  32'h0000_012c
`define MTX_RATE_600  32'h0000_0258
`define MTX_RATE_1200 32'h0000_04b0
`define MTX_RATE_2400 32'h0000_0960

// ----------------------------------------------------------------------------
// Stop shortening, scrambler and reset values
// ----------------------------------------------------------------------------
`define MTX_SHORT_DIV  32'h0000_0008
`define MTX_SCR_TAP_A  14
`define MTX_SCR_TAP_B  17
`define MTX_ONES_LIMIT 7'h40
`define MTX_READY_RST  1'b1

`endif

// ===== mtx_pkg.sv
package mtx_pkg;

  typedef enum logic [2:0] {
    MTX_FSK_300,
    MTX_FSK_1200,
    MTX_FSK_75,
    MTX_FSK_150,
    MTX_DPSK_600,
    MTX_DPSK_1200,
    MTX_QAM_2400,
    MTX_OFF
  } mtx_modem_e;

  typedef enum logic [2:0] {
    MTX_S_IDLE,
    MTX_S_START,
    MTX_S_DATA,
    MTX_S_PARITY,
    MTX_S_STOP
  } mtx_state_e;

endpackage

// ===== mtx_host_model.sv
`timescale 1ns/1ps
module mtx_host_model
(
  output logic link_clk,
  output logic cs_b,
  output logic cmd_data
);
  // ----------------------------------------
  // Host frame writer
  // ----------------------------------------
  initial
  begin
    link_clk = 1'b0;
    cs_b     = 1'b0;
    cmd_data = 1'b1;
    // Select rises after time zero so the frame counter sees a real edge
    #1;
    cs_b     = 1'b1;
  end

  // Address byte, then one data byte, MSB first
  // Link clock stands still low between frames
  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {addr, data};
    cs_b = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      cmd_data = frame[i];
      #32;
      link_clk = 1'b1;
      #32;
      link_clk = 1'b0;
    end
    #32;
    cs_b = 1'b1;
    // Released line flips so a stale bit never looks valid
    cmd_data = ~frame[0];
  endtask
endmodule

// ===== mtx_serializer_bench.sv
`timescale 1ns/1ps
`include "mtx_params.svh"
module mtx_serializer_bench
  import mtx_pkg::*;
  ;
  // Short bit period keeps the run brief
  localparam int DIV = 64;

  logic       clk, rst_b, link_clk, cs_b, cmd_data;
  mtx_modem_e tx_modem;
  logic       start_stop, parity_en, parity_even, two_stop;
  logic       scram_en, answer_mode, powersave, tx_ready, tx_underflow;
  logic       line_bit, bit_strobe, fsk_active, carrier_high, sym_strobe;
  logic [1:0] data_bits, phase_change, quad_point;
  logic       bits[$];
  logic       exp_q[$];
  int         stamps[$];
  int         cyc = 0, n_sym = 0, n_mismatch = 0, checks_done = 0;
  bit         sym_on;

`define CHK(name, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s expected %0h seen %0h", name, exp, got); \
    end \
  end

  mtx_serializer #(
    .DIV_75(DIV), .DIV_150(DIV), .DIV_300(DIV),
    .DIV_600(DIV), .DIV_1200(DIV), .DIV_2400(DIV)
  ) dut (
    .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .cs_b(cs_b),
    .cmd_data(cmd_data), .tx_modem(tx_modem), .start_stop(start_stop),
    .data_bits(data_bits), .parity_en(parity_en), .parity_even(parity_even),
    .two_stop(two_stop), .scram_en(scram_en), .answer_mode(answer_mode),
    .powersave(powersave), .tx_ready(tx_ready), .tx_underflow(tx_underflow),
    .line_bit(line_bit), .bit_strobe(bit_strobe), .fsk_active(fsk_active),
    .carrier_high(carrier_high), .phase_change(phase_change),
    .quad_point(quad_point), .sym_strobe(sym_strobe)
  );

  mtx_host_model host (
    .link_clk (link_clk),
    .cs_b     (cs_b),
    .cmd_data (cmd_data)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cfg(input mtx_modem_e m, input logic ss, input logic [1:0] db,
                     input logic pe, input logic ts, input logic sc);
    tx_modem    = m;
    start_stop  = ss;
    data_bits   = db;
    parity_en   = pe;
    parity_even = db[1];
    two_stop    = ts;
    scram_en    = sc;
    bits.delete();
    stamps.delete();
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_bits(input int n);
    for (int i = 0; i < (n + 8) * DIV && bits.size() < n; i++)
      @(posedge clk);
    #1;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 400 && tx_ready !== 1'b1; i++)
      @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.send(a, d);
    cyc_wait(8);
  endtask

  task automatic mk_char(input logic [7:0] b, input int n, input int stops);
    logic [7:0] m;
    m = b & ~(8'hff << n);
    exp_q.push_back(1'b0);
    for (int i = 0; i < n; i++)
      exp_q.push_back(b[i]);
    if (parity_en)
      exp_q.push_back(parity_even ? ^m : ~^m);
    repeat (stops)
      exp_q.push_back(1'b1);
  endtask

  function automatic int first_zero();
    int k;
    k = 0;
    while (k < bits.size() && bits[k] === 1'b1)
      k++;
    return k;
  endfunction

  // Idle stop bits ahead of the start bit are skipped
  task automatic chk_bits();
    int k;
    k = first_zero();
    for (int i = 0; i < exp_q.size(); i++)
      `CHK("line_bit", exp_q[i], (k + i < bits.size()) ? bits[k + i] : 1'bx)
    exp_q.delete();
  endtask

  // Pair {first, second}: 00 +90, 01 0, 11 +270, 10 +180, in 90-degree steps
  function automatic logic [1:0] dibit(input logic f, input logic s);
    return {f, f ~^ s};
  endfunction

  task automatic chk_sym();
    int n;
    n = bits.size();
    n_sym++;
    if (tx_modem == MTX_DPSK_600)
      `CHK("phase", bits[n - 1] ? 2'h3 : 2'h1, phase_change)
    else if (tx_modem == MTX_DPSK_1200)
      `CHK("phase", dibit(bits[n - 2], bits[n - 1]), phase_change)
    else
    begin
      `CHK("phase", dibit(bits[n - 4], bits[n - 3]), phase_change)
      `CHK("point", {bits[n - 2], bits[n - 1]}, quad_point)
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (bit_strobe === 1'b1)
    begin
      bits.push_back(line_bit);
      stamps.push_back(cyc);
    end
    if (sym_on && sym_strobe === 1'b1 && bits.size() >= 4)
      chk_sym();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("tx_ready", 1'b1, tx_ready)
    `CHK("tx_underflow", 1'b0, tx_underflow)
    `CHK("line_bit", 1'b1, line_bit)
    $display("test reset done");
  endtask

  task automatic t_standby();
    cfg(MTX_FSK_300, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0);
    powersave = 1'b1;
    wr(`MTX_ADDR_TX_NORMAL, 8'h3c);
    cyc_wait(5 * DIV);
    `CHK("tx_ready", 1'b0, tx_ready)
    `CHK("strobes", 0, bits.size())
    `CHK("line_bit", 1'b1, line_bit)
    powersave = 1'b0;
    wait_bits(16);
    mk_char(8'h3c, 8, 2);
    chk_bits();
    `CHK("tx_underflow", 1'b1, tx_underflow)
    $display("test standby done");
  endtask

  task automatic t_chars();
    mtx_modem_e fm[4] = '{MTX_FSK_300, MTX_FSK_1200, MTX_FSK_75, MTX_FSK_150};
    for (int i = 0; i < 4; i++)
    begin
      cfg(fm[i], 1'b1, i[1:0], i[0], i == 3, 1'b0);
      wr(`MTX_ADDR_TX_NORMAL, 8'ha5 ^ i[7:0]);
      `CHK("tx_underflow", 1'b0, tx_underflow)
      `CHK("fsk_active", 1'b1, fsk_active)
      wait_bits(i + 22);
      mk_char(8'ha5 ^ i[7:0], i + 5, (i == 3) ? 3 : 2);
      chk_bits();
      `CHK("tx_underflow", 1'b1, tx_underflow)
    end
    $display("test chars done");
  endtask

  task automatic t_sync();
    mtx_modem_e pm[3] = '{MTX_DPSK_600, MTX_DPSK_1200, MTX_QAM_2400};
    logic [7:0] b = 8'h1e;
    for (int i = 0; i < 3; i++)
    begin
      cfg(MTX_OFF, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0);
      wr(`MTX_ADDR_TX_SHORT, b);
      answer_mode = i[0];
      sym_on = 1'b1;
      cfg(pm[i], 1'b0, 2'h3, 1'b0, 1'b0, 1'b0);
      wait_bits(24);
      for (int j = 0; j < 24; j++)
        `CHK("sync bit", b[j % 8], bits[j])
      `CHK("tx_underflow", 1'b1, tx_underflow)
      `CHK("fsk_active", 1'b0, fsk_active)
      `CHK("carrier_high", i[0], carrier_high)
      sym_on = 1'b0;
    end
    `CHK("symbols", 1'b1, n_sym > 0)
    $display("test sync done");
  endtask

  task automatic t_short();
    int k;
    // One idle cycle drops any unfinished sync word ahead of the first start bit
    cfg(MTX_OFF, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0);
    cyc_wait(1);
    cfg(MTX_QAM_2400, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0);
    // One shortened character followed by a normal one
    wr(`MTX_ADDR_TX_SHORT, 8'h5a);
    wait_ready();
    wr(`MTX_ADDR_TX_NORMAL, 8'hc3);
    wait_bits(30);
    mk_char(8'h5a, 8, 0);
    mk_char(8'hc3, 8, 2);
    chk_bits();
    cfg(MTX_FSK_1200, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0);
    wr(`MTX_ADDR_TX_SHORT, 8'h00);
    wait_ready();
    wr(`MTX_ADDR_TX_NORMAL, 8'h00);
    wait_bits(30);
    k = first_zero();
    `CHK("short stop", DIV - DIV / 8, stamps[k + 10] - stamps[k + 9])
    `CHK("full stop", DIV, stamps[k + 20] - stamps[k + 19])
    $display("test short stop done");
  endtask

  task automatic t_scram();
    int   last;
    int   nz;
    logic d;
    last = -1;
    nz = 0;
    cfg(MTX_OFF, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0);
    wr(`MTX_ADDR_TX_NORMAL, 8'hff);
    cfg(MTX_DPSK_600, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0);
    wait_bits(16);
    for (int j = 0; j < 16; j++)
      `CHK("plain bit", 1'b1, bits[j])
    cfg(MTX_DPSK_600, 1'b0, 2'h3, 1'b0, 1'b0, 1'b1);
    wait_bits(220);
    // Descrambled stream must be all ones bar one forced zero per run
    for (int j = 17; j < bits.size(); j++)
    begin
      d = bits[j] ^ bits[j - 14] ^ bits[j - 17];
      if (d !== 1'b1)
      begin
        if (last >= 0)
          `CHK("ones run", 65, j - last)
        nz++;
        last = j;
      end
    end
    `CHK("inversions", 1'b1, nz >= 2)
    $display("test scrambler done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    rst_b       = 1'b1;
    answer_mode = 1'b0;
    powersave   = 1'b0;
    sym_on      = 1'b0;
    cfg(MTX_OFF, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    // Reset falls after time zero so the link registers see a real edge
    #1;
    rst_b = 1'b0;
    cyc_wait(16);
    rst_b = 1'b1;
    cyc_wait(2);
    t_reset();
    t_standby();
    t_chars();
    t_sync();
    t_short();
    t_scram();
    results();
  end

  // Tests take about 32k cycles; 60k leaves ample slack
  initial
  begin
    #300000;
    n_mismatch++;
    results();
  end
endmodule
